// >>> intc_core.sv
// Purpose : Interrupt enable, two-level priority, polling and vector
//           generation for fifteen sources, with an AXI4-Lite port.
// Assumes : Request flags and core handshake are on aclk.
// Notes   : Outputs are taken straight from the state register.
`timescale 1ns/1ps
`default_nettype none

module intc_core
  import intc_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]     awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0]     wdata,
  input  wire logic [STRB_W-1:0]     wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  // AXI4-Lite write response
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]     araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]          rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // Peripheral request flags, indexed by source id
  input  wire logic [NUM_SRC-1:0]    src_req,
  // Processor core handshake
  input  wire logic                  core_take,
  input  wire logic                  core_return,
  output logic                       core_req,
  output logic                       core_req_high,
  output logic [VEC_W-1:0]           core_vector,
  // Event interrupt
  output logic                       irq
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic                aw_held;
    logic [ADDR_W-1:0]   aw_addr;
    logic                awready;
    logic                w_held;
    logic [7:0]          w_byte;
    logic                w_lane0;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [DATA_W-1:0]   rdata;
    logic [1:0]          rresp;
    logic [7:0]          base_en;
    logic [7:0]          t2_en;
    logic [7:0]          base_pri;
    logic [7:0]          t2_pri;
    logic [EV_W-1:0]     ev_stat;
    logic [EV_W-1:0]     ev_mask;
    logic                irq;
    logic                act_hi;
    logic                act_lo;
    logic                req_valid;
    logic                req_high;
    logic [VEC_W-1:0]    vector;
  } state_t;

  localparam state_t RESET_STATE = '{
    base_en:  RST_BASE_EN,
    t2_en:    RST_T2_EN,
    base_pri: RST_BASE_PRI,
    t2_pri:   RST_T2_PRI,
    ev_stat:  RST_EV,
    ev_mask:  RST_EV,
    default:  '0
  };

  state_t s_r;
  state_t s_nxt;

  // ------------------------------------------------------------------
  // Per-source enable and level vectors, indexed by source id
  // ------------------------------------------------------------------
  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] pri_vec;
  logic [NUM_SRC-1:0] elig;
  logic [NUM_SRC-1:0] hi_cand;
  logic [NUM_SRC-1:0] lo_cand;

  // Id 14 overflow, 13..11 compare 2..0, 10 converter,
  // 9..6 capture 3..0, 5..0 base sources
  assign en_vec = {s_r.t2_en[7],
                   s_r.t2_en[6:4],
                   s_r.base_en[6],
                   s_r.t2_en[3:0],
                   s_r.base_en[5:0]};

  // Bit 7 of the base level register never enters the vector
  assign pri_vec = {s_r.t2_pri[7:4],
                    s_r.base_pri[6],
                    s_r.t2_pri[3:0],
                    s_r.base_pri[5:0]};

  // Id 2 is one slot shared by external one and the seconds timer
  assign elig = src_req & en_vec
              & {NUM_SRC{s_r.base_en[GLOBAL_GATE_BIT]}};

  assign hi_cand = elig & pri_vec;
  assign lo_cand = elig & ~pri_vec;

  // ------------------------------------------------------------------
  // Polling within each level
  // ------------------------------------------------------------------
  logic [NUM_SRC-1:0]   hi_poll;
  logic [NUM_SRC-1:0]   lo_poll;
  logic                 hi_hit;
  logic                 lo_hit;
  logic [SRC_IDX_W-1:0] hi_pos;
  logic [SRC_IDX_W-1:0] lo_pos;

  always_comb begin
    for (int p = 0; p < NUM_SRC; p++) begin
      hi_poll[p] = hi_cand[POLL_ORDER[p]];
      lo_poll[p] = lo_cand[POLL_ORDER[p]];
    end
  end

  poll_select #(
    .N   (NUM_SRC),
    .W   (SRC_IDX_W)
  ) u_poll_hi (
    .req (hi_poll),
    .hit (hi_hit),
    .pos (hi_pos)
  );

  poll_select #(
    .N   (NUM_SRC),
    .W   (SRC_IDX_W)
  ) u_poll_lo (
    .req (lo_poll),
    .hit (lo_hit),
    .pos (lo_pos)
  );

  // ------------------------------------------------------------------
  // Level arbitration and vector
  // ------------------------------------------------------------------
  logic                 pick_hi;
  logic                 pick_lo;
  logic [SRC_IDX_W-1:0] win_id;
  logic [VEC_W-1:0]     win_vec;

  // A running high routine blocks all; a running low one only low
  assign pick_hi = hi_hit && !s_r.act_hi;
  assign pick_lo = !pick_hi && lo_hit
                && !s_r.act_hi && !s_r.act_lo;
  assign win_id  = pick_hi ? POLL_ORDER[hi_pos] : POLL_ORDER[lo_pos];
  assign win_vec = VEC_BASE + {9'h000, win_id, 3'h0};

  // ------------------------------------------------------------------
  // Read decode
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] rd_data;
  logic              rd_ok;
  logic [DATA_W-1:0] core_stat;

  always_comb begin
    core_stat = '0;
    core_stat[CS_ACT_LO] = s_r.act_lo;
    core_stat[CS_ACT_HI] = s_r.act_hi;
    core_stat[CS_REQ]    = s_r.req_valid;
    core_stat[CS_REQ_HI] = s_r.req_high;
    core_stat[CS_VEC_LSB +: VEC_W] = s_r.vector;
  end

  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b1;
    case (araddr)
      OFS_BASE_EN:   rd_data[7:0] = s_r.base_en;
      OFS_EV_STAT:   rd_data[EV_W-1:0] = s_r.ev_stat;
      OFS_EV_MASK:   rd_data[EV_W-1:0] = s_r.ev_mask;
      OFS_CORE_STAT: rd_data = core_stat;
      OFS_BASE_PRI:  rd_data[7:0] = s_r.base_pri;
      OFS_T2_EN:     rd_data[7:0] = s_r.t2_en;
      OFS_T2_PRI:    rd_data[7:0] = s_r.t2_pri;
      default:       rd_ok = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic            take;

  assign take = core_take && s_r.req_valid;

  always_comb begin
    s_nxt  = s_r;
    ev_clr = '0;
    ev_set = '0;

    // Address and data are captured independently, in either order
    if (s_r.awready && awvalid) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = awaddr;
    end
    if (s_r.wready && wvalid) begin
      s_nxt.w_held  = 1'b1;
      s_nxt.w_byte  = wdata[7:0];
      s_nxt.w_lane0 = wstrb[0];
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Commit only once the previous response has been taken
    if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = RESP_OKAY;
      case (s_r.aw_addr)
        OFS_BASE_EN: begin
          if (s_r.w_lane0) begin
            s_nxt.base_en = s_r.w_byte;
          end
        end
        OFS_EV_STAT: begin
          if (s_r.w_lane0) begin
            ev_clr = s_r.w_byte[EV_W-1:0];
          end
        end
        OFS_EV_MASK: begin
          if (s_r.w_lane0) begin
            s_nxt.ev_mask = s_r.w_byte[EV_W-1:0];
          end
        end
        OFS_CORE_STAT: begin
          s_nxt.bresp = RESP_OKAY;
        end
        OFS_BASE_PRI: begin
          if (s_r.w_lane0) begin
            s_nxt.base_pri = s_r.w_byte & ~BASE_PRI_RSVD;
          end
        end
        OFS_T2_EN: begin
          if (s_r.w_lane0) begin
            s_nxt.t2_en = s_r.w_byte;
          end
        end
        OFS_T2_PRI: begin
          if (s_r.w_lane0) begin
            s_nxt.t2_pri = s_r.w_byte;
          end
        end
        default: s_nxt.bresp = RESP_SLVERR;
      endcase
    end
    s_nxt.awready = !s_nxt.aw_held;
    s_nxt.wready  = !s_nxt.w_held;

    // Read channel: one outstanding read at a time
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_r.arready && arvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd_data;
      s_nxt.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    s_nxt.arready = !s_nxt.rvalid;

    // Level-active flags follow the core's take and return
    if (take) begin
      if (s_r.req_high) begin
        s_nxt.act_hi = 1'b1;
        ev_set[EV_TAKE_HI] = 1'b1;
      end else begin
        s_nxt.act_lo = 1'b1;
        ev_set[EV_TAKE_LO] = 1'b1;
      end
    end else if (core_return) begin
      // Return closes the innermost routine unless a take comes in the same cycle
      if (s_r.act_hi) begin
        s_nxt.act_hi = 1'b0;
      end else begin
        s_nxt.act_lo = 1'b0;
      end
      ev_set[EV_RETURN] = 1'b1;
    end

    // Hold off one cycle after take or return so the offer is always
    // judged against the updated level flags
    s_nxt.req_valid = (pick_hi || pick_lo)
                    && !core_take && !core_return;
    s_nxt.req_high  = pick_hi;
    s_nxt.vector    = win_vec;

    // A new event wins over a clear in the same cycle
    s_nxt.ev_stat = (s_r.ev_stat & ~ev_clr) | ev_set;
    s_nxt.irq     = |(s_nxt.ev_stat & s_nxt.ev_mask);
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign awready       = s_r.awready;
  assign wready        = s_r.wready;
  assign bvalid        = s_r.bvalid;
  assign bresp         = s_r.bresp;
  assign arready       = s_r.arready;
  assign rvalid        = s_r.rvalid;
  assign rdata         = s_r.rdata;
  assign rresp         = s_r.rresp;
  assign core_req      = s_r.req_valid;
  assign core_req_high = s_r.req_high;
  assign core_vector   = s_r.vector;
  assign irq           = s_r.irq;

endmodule

`default_nettype wire

// >>> intc_pkg.sv
// Purpose : Shared constants for the interrupt enable, priority and
//           vectoring block.
// Assumes : AXI4-Lite register access, 32-bit data, byte offsets.
// Notes   : Source ids follow the order of the vector table.
package intc_pkg;

  // ------------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned STRB_W    = DATA_W / 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_BASE_EN   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_EV_STAT   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EV_MASK   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CORE_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_BASE_PRI  = 8'hb8;
  localparam logic [ADDR_W-1:0] OFS_T2_EN     = 8'he8;
  localparam logic [ADDR_W-1:0] OFS_T2_PRI    = 8'hf8;

  // ------------------------------------------------------------------
  // Reset values and field positions
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_BASE_EN  = 8'h00;
  localparam logic [7:0] RST_T2_EN    = 8'h00;
  localparam logic [7:0] RST_BASE_PRI = 8'h00;
  localparam logic [7:0] RST_T2_PRI   = 8'h00;
  localparam int unsigned GLOBAL_GATE_BIT = 7;
  localparam logic [7:0]  BASE_PRI_RSVD   = 8'h80;

  // Event status / mask layout
  localparam int unsigned EV_W       = 3;
  localparam int unsigned EV_TAKE_HI = 0;
  localparam int unsigned EV_TAKE_LO = 1;
  localparam int unsigned EV_RETURN  = 2;
  localparam logic [EV_W-1:0] RST_EV = 3'h0;

  // Core status layout
  localparam int unsigned CS_ACT_LO  = 0;
  localparam int unsigned CS_ACT_HI  = 1;
  localparam int unsigned CS_REQ     = 2;
  localparam int unsigned CS_REQ_HI  = 3;
  localparam int unsigned CS_VEC_LSB = 8;

  // ------------------------------------------------------------------
  // Sources, vectors and polling order
  // ------------------------------------------------------------------
  localparam int unsigned NUM_SRC   = 15;
  localparam int unsigned SRC_IDX_W = 4;
  localparam int unsigned VEC_W     = 16;
  localparam logic [VEC_W-1:0] VEC_BASE = 16'h0003;

  // Polling position -> source id, position 0 served first
  localparam logic [NUM_SRC-1:0][SRC_IDX_W-1:0] POLL_ORDER = {
    4'he, 4'h9, 4'h4, 4'hd, 4'h8, 4'h3, 4'hc, 4'h7,
    4'h2, 4'hb, 4'h6, 4'h1, 4'ha, 4'h5, 4'h0
  };

endpackage

// >>> poll_select.sv
// Purpose : Fixed-order poller; lowest set position wins.
// Assumes : Requests already arranged in polling order.
// Notes   : Purely combinational.
`timescale 1ns/1ps
`default_nettype none

module poll_select #(
  parameter int unsigned N = 15,
  parameter int unsigned W = 4
) (
  // Requests in polling order
  input  wire logic [N-1:0] req,
  // Result
  output logic              hit,
  output logic [W-1:0]      pos
);

  always_comb begin
    hit = |req;
    pos = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        pos = W'(i);
      end
    end
  end

endmodule

`default_nettype wire

// >>> intc_props.sv
// Purpose : Port-level assertions for intc_core
// Assumes : One aclk domain, synchronous active-low aresetn
// Notes   : Bound from tb_top; sees top ports only
`timescale 1ns/1ps
`default_nettype none
module intc_props (
  // Clock and reset
  input wire logic                         aclk,
  input wire logic                         aresetn,
  // Bus handshakes and answers
  input wire logic                         awvalid,
  input wire logic                         awready,
  input wire logic                         wvalid,
  input wire logic                         wready,
  input wire logic                         bvalid,
  input wire logic                         bready,
  input wire logic                         arvalid,
  input wire logic                         arready,
  input wire logic                         rvalid,
  input wire logic                         rready,
  input wire logic [1:0]                   bresp,
  input wire logic [intc_pkg::DATA_W-1:0]  rdata,
  // Requests and core handshake
  input wire logic [intc_pkg::NUM_SRC-1:0] src_req,
  input wire logic                         core_take,
  input wire logic                         core_return,
  input wire logic                         core_req,
  input wire logic                         core_req_high,
  input wire logic [intc_pkg::VEC_W-1:0]   core_vector
);
  import intc_pkg::*;
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  vec_table_a: assert property (
    core_req |-> core_vector[2:0] == 3'h3
    && core_vector <= 16'h0073) else $error("vector off the table");
  idle_quiet_a: assert property (
    $past(src_req) == '0 |-> !core_req)
    else $error("offer with no flag set");
  take_clears_a: assert property (
    core_take && core_req |=> !core_req)
    else $error("offer kept after take");
  // Three quiet cycles cover the two-cycle offer latency after a return
  low_blocked_a: assert property (
    (core_take && core_req && !core_req_high) ##1 !core_return [*3]
    |-> !(core_req && !core_req_high)) else $error("low offer in low");
  high_blocked_a: assert property (
    (core_take && core_req && core_req_high) ##1 !core_return [*3]
    |-> !core_req) else $error("offer during high routine");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  wr_answer_a: assert property (awvalid && awready && wvalid && wready
    |=> ##1 bvalid) else $error("write not answered in two cycles");
endmodule
`default_nettype wire

// >>> core_model.sv
// Purpose : Processor core stand-in that takes offered vectors
// Assumes : Same aclk as the block, synchronous active-low reset
// Notes   : take_wait stretches the reply to play a slow core
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // Offer from the block
  input  wire logic                       core_req,
  input  wire logic [intc_pkg::VEC_W-1:0] core_vector,
  // Bench control
  input  wire logic                       take_en,
  input  wire logic [3:0]                 take_wait,
  // Reply and record
  output logic                            core_take,
  output logic [intc_pkg::VEC_W-1:0]      last_vec,
  output logic [7:0]                      take_cnt
);
  import intc_pkg::*;
  logic [3:0] wait_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_take <= 1'b0;
      wait_cnt  <= 4'h0;
      last_vec  <= '0;
      take_cnt  <= 8'h0;
    end else if (core_take) begin
      // One-cycle pulse; an offer that vanished meanwhile is not counted
      core_take <= 1'b0;
      wait_cnt  <= 4'h0;
      if (core_req) begin
        last_vec <= core_vector;
        take_cnt <= take_cnt + 8'h1;
      end
    end else if (take_en && core_req) begin
      if (wait_cnt >= take_wait) begin
        core_take <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      wait_cnt <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
// Purpose : Self-checking bench for intc_core
// Assumes : 20 MHz aclk, core model takes only when allowed
// Notes   : Each scenario task judges its own results
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import intc_pkg::*;
  logic              aclk, aresetn, awvalid, awready, wvalid, wready;
  logic              bvalid, bready, arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [STRB_W-1:0] wstrb;
  logic [1:0]        bresp, rresp;
  logic [NUM_SRC-1:0] src_req;
  logic core_take, core_return, core_req, core_req_high, irq, take_en;
  logic [VEC_W-1:0]  core_vector, last_vec;
  logic [3:0]        take_wait;
  logic [7:0]        take_cnt;
  int error_cnt, check_count, cyc;
  int ord [15] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};
  // ----
  // Clock, design and core
  // ----
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  intc_core i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .src_req, .core_take,
    .core_return, .core_req, .core_req_high, .core_vector, .irq);
  core_model i_core (.aclk, .aresetn, .core_req, .core_vector, .take_en,
    .take_wait, .core_take, .last_vec, .take_cnt);
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Response ready is raised late so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b1;
    @(posedge aclk);
    chk("bresp", 32'(er), 32'(bresp));
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b1;
    @(posedge aclk);
    chk("rdata", ed, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    rready <= 1'b0;
  endtask
  task automatic ret();
    @(posedge aclk);
    core_return <= 1'b1;
    @(posedge aclk);
    core_return <= 1'b0;
  endtask
  task automatic take_one(input logic [15:0] ev, input logic eh);
    logic [7:0] c0;
    #1;
    while (core_req !== 1'b1) begin
      @(posedge aclk);
      #1;
    end
    chk("vector", 32'(ev), 32'(core_vector));
    chk("level", 32'(eh), 32'(core_req_high));
    c0 = take_cnt;
    @(posedge aclk);
    take_en <= 1'b1;
    while (take_cnt === c0) begin
      @(posedge aclk);
    end
    take_en <= 1'b0;
    chk("taken", 32'(ev), 32'(last_vec));
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    rd(8'hb8, 32'h0);
    rd(8'he8, 32'h0);
    rd(8'hf8, 32'h0);
    wr(8'hb8, 32'hff);
    rd(8'hb8, 32'h7f);
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'hb8, 32'h0);
  endtask
  task automatic t_gates();
    wr(8'h00, 32'h80);
    src_req <= 15'h7fff;
    tick(4);
    chk("all disabled", 32'h0, 32'(core_req));
    for (int b = 0; b < 8; b++) begin
      wr(8'he8, 32'(1 << b));
      take_one(16'(3 + 8 * (b > 3 ? b + 7 : b + 6)),
               1'b0);
      ret();
    end
    wr(8'he8, 32'h0);
    for (int b = 0; b < 7; b++) begin
      wr(8'h00, 32'(8'h80 | (1 << b)));
      take_one(16'(3 + 8 * (b == 6 ? 10 : b)), 1'b0);
      ret();
    end
  endtask
  task automatic t_poll();
    wr(8'h00, 32'hff);
    wr(8'he8, 32'hff);
    take_wait <= 4'h3;
    foreach (ord[k]) begin
      take_one(16'(3 + 8 * ord[k]), 1'b0);
      src_req[ord[k]] <= 1'b0;
      ret();
    end
    take_wait <= 4'h0;
  endtask
  task automatic t_prio();
    int id;
    src_req <= 15'h7fff;
    // Each level bit alone lifts exactly its own source above the rest
    for (int b = 0; b < 15; b++) begin
      id = (b > 7) ? (b == 14 ? 10 : b - 8) : (b > 3 ? b + 7 : b + 6);
      wr(b > 7 ? 8'hb8 : 8'hf8, 32'(1 << (b % 8)));
      take_one(16'(3 + 8 * id), 1'b1);
      ret();
      wr(b > 7 ? 8'hb8 : 8'hf8, 32'h0);
    end
    wr(8'hb8, 32'h80);
    take_one(16'h0003, 1'b0);
    wr(8'hf8, 32'h80);
    take_one(16'h0073, 1'b1);
    tick(4);
    chk("offer in high", 32'h0, 32'(core_req));
    ret();
    ret();
    wr(8'hf8, 32'h0);
    wr(8'hb8, 32'h40);
    take_one(16'h0053, 1'b1);
    ret();
    wr(8'hb8, 32'h0);
    wr(8'h00, 32'h7f);
    tick(4);
    chk("gate off", 32'h0, 32'(core_req));
  endtask
  task automatic t_irq();
    src_req <= 15'h0001;
    wr(8'h00, 32'h81);
    wr(8'h04, 32'h7);
    // Status is read-only: a write answers OKAY and changes nothing
    wr(8'h0c, 32'hff);
    rd(8'h0c, 32'h0000_0304);
    take_one(16'h0003, 1'b0);
    src_req <= 15'h0;
    ret();
    tick(3);
    chk("irq masked", 32'h0, 32'(irq));
    rd(8'h04, 32'h6);
    wr(8'h08, 32'h2);
    tick(2);
    chk("irq", 32'h1, 32'(irq));
    wr(8'h04, 32'h2);
    tick(2);
    chk("irq cleared", 32'h0, 32'(irq));
    rd(8'h04, 32'h4);
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, src_req} = '0;
    {core_return, take_en, take_wait} = '0;
    wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_gates();
    t_poll();
    t_prio();
    t_irq();
    print_verdict();
  end
endmodule
bind intc_core intc_props i_props (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready,
  .bresp, .rdata, .src_req, .core_take, .core_return, .core_req,
  .core_req_high, .core_vector);
`default_nettype wire
